// ===== rtl/rbf_pkg.sv
// Package for the baseband control block
// Notes on behaviour
// R1 - Two-bit code picks prefilter cutoff
// R2 - Filter clock is twenty times cutoff
// R3 - Filter clock is crystal over twice divider
// R4 - Bypass bit skips and stops filter
// R5 - Demodulator gives up and down pulses
// R6 - Mode: off, up, down, or up minus down
// R7 - Length code picks 8, 16, 32, 64 symbols
// R8 - Result readable at address 0x16
// R9 - Negative results only in down modes
// R10 - Host should prefer combined mode
// R11 - Synchronizer runs only in receive with sync
// R12 - Data clock equals recovered bit rate
// R13 - Bit changes on rising, host samples falling
// R14 - Sync clock is crystal over K times power
// R15 - Reference divider 1..63, sync setting 0..7
// R16 - One reference divider feeds sync and rate clocks
// R17 - Synchronizer locks within 22 bits
// R18 - Power code zero turns amplifier off
// R19 - Amp bypass keeps power steps
// R20 - Sync enable bit in register zero
// R21 - Result counter wraps modulo 256
// R22 - Nonzero mode write clears, counts, then freezes
// R23 - Zero divider keeps derived clock stopped
package rbf_pkg;

   localparam int ADDR_W = 7;
   localparam logic [6:0] ADDR_MAIN = 7'h00;
   localparam logic [6:0] ADDR_DETECT = 7'h01;
   localparam logic [6:0] ADDR_SYNC_HI = 7'h06;
   localparam logic [6:0] ADDR_RATE_REF = 7'h07;
   localparam logic [6:0] ADDR_FILT_DIV = 7'h08;
   localparam logic [6:0] ADDR_BYPASS = 7'h09;
   localparam logic [6:0] ADDR_EST_CTL = 7'h15;
   localparam logic [6:0] ADDR_EST_RES = 7'h16;

   // Writable and fixed bits; fixed bits are the reset
   localparam logic [7:0] MAIN_WMASK = 8'hfe;
   localparam logic [7:0] MAIN_FIXED = 8'h01;
   localparam logic [7:0] DETECT_WMASK = 8'h0f;
   localparam logic [7:0] DETECT_FIXED = 8'h80;
   localparam logic [7:0] SYNC_WMASK = 8'h0f;
   localparam logic [7:0] SYNC_FIXED = 8'h00;
   localparam logic [7:0] RATE_WMASK = 8'hff;
   localparam logic [7:0] RATE_FIXED = 8'h00;
   localparam logic [7:0] FILT_WMASK = 8'h3f;
   localparam logic [7:0] FILT_FIXED = 8'hc0;
   localparam logic [7:0] BYP_WMASK = 8'h03;
   localparam logic [7:0] BYP_FIXED = 8'h00;
   localparam logic [7:0] EST_WMASK = 8'h0f;
   localparam logic [7:0] EST_FIXED = 8'h00;

   localparam int POW_TOP = 7;
   localparam int OVERSAMPLE = 16;
   localparam logic [3:0] PHASE_SAMPLE = 4'h8;
   localparam logic [3:0] PHASE_EDGE = 4'h0;
   localparam logic [4:0] LOCK_BITS = 5'h16;
   localparam logic [6:0] EST_BASE_LEN = 7'h08;

   typedef enum logic [1:0] {
      OP_POWER_DOWN = 2'b00,
      OP_STANDBY = 2'b01,
      OP_RECEIVE = 2'b10,
      OP_TRANSMIT = 2'b11
   } rbf_op_t;

   typedef enum logic [1:0] {
      EST_OFF = 2'b00,
      EST_UP = 2'b01,
      EST_DOWN = 2'b10,
      EST_BOTH = 2'b11
   } rbf_est_t;

   // Decoded control bytes
   typedef struct packed {
      logic front_amp_bypass;
      logic [2:0] amp_power_step;
      logic sync_en;
      rbf_op_t operating_state;
      logic signal_level_detector_enable;
      logic pll_lock_indicator_enable;
      logic [1:0] prefilter_cutoff_sel;
      logic [2:0] sync_clock_setting;
      logic [2:0] rate_clock_setting;
      logic [5:0] reference_divider;
      logic [5:0] channel_filter_divider;
      logic channel_filter_bypass;
      logic amp_bypass;
      rbf_est_t error_est_mode;
      logic [1:0] error_est_length;
   } rbf_cfg_t;

endpackage : rbf_pkg

// ===== rtl/rbf_fifo.sv
// Synchronous FIFO with valid/ready
`timescale 1ns/1ps
`default_nettype none
module rbf_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Fill side
   input wire logic wr_valid,
   input wire logic [WIDTH-1:0] wr_data,
   output logic wr_ready,
   // Drain side
   output logic rd_valid,
   output logic [WIDTH-1:0] rd_data,
   input wire logic rd_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign wr_ready = (count != (AW+1)'(DEPTH));
   assign rd_valid = (count != '0);
   assign rd_data = mem[rd_ptr];
   assign push = wr_valid && wr_ready;
   assign pop = rd_valid && rd_ready;

   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= wr_data;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop)
         begin
            count <= count + 1'b1;
         end
         else if (pop && !push)
         begin
            count <= count - 1'b1;
         end
      end
   end

endmodule : rbf_fifo
`default_nettype wire

// ===== rtl/rbf_ctrl.sv
// Baseband, estimator, synchronizer and amplifier control
`timescale 1ns/1ps
`default_nettype none
module rbf_ctrl
   import rbf_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Demodulator
   input wire logic rx_bit_raw,
   input wire logic demod_up,
   input wire logic demod_dn,
   // Data interface pins
   output logic data_clock_pin,
   input wire logic data_io_pin_in,
   output logic data_io_pin_out,
   output logic data_io_pin_oe,
   output logic tx_bit,
   output logic sync_locked,
   // Analog controls
   output logic [1:0] prefilter_cutoff_sel,
   output logic channel_filter_clk,
   output logic channel_filter_enable,
   output logic channel_filter_bypass,
   output logic signal_level_detector_enable,
   output logic pll_lock_indicator_enable,
   output logic amp_on,
   output logic [2:0] amp_power_step,
   output logic amp_bypass,
   output logic front_amp_bypass
);

   function automatic logic [6:0] pow_limit(input logic [2:0] setting);
      pow_limit = 7'((8'h01 << (3'(POW_TOP) - setting)) - 8'h01);
   endfunction : pow_limit

   function automatic logic [7:0] masked(input logic [7:0] wdata,
                                         input logic [7:0] wmask,
                                         input logic [7:0] fixed);
      masked = (wdata & wmask) | fixed;
   endfunction : masked

   // Stored control bytes
   logic [7:0] main_mode_power_control;
   logic [7:0] detector_and_prefilter_control;
   logic [7:0] sync_clock_select_high;
   logic [7:0] rate_select_and_reference_divider;
   logic [7:0] channel_filter_clock_divider;
   logic [7:0] bypass_control;
   logic [7:0] freq_error_control;
   logic [7:0] freq_error_result;
   rbf_cfg_t cfg;

   // Clocks and synchronizer state
   logic [5:0] ref_cnt;
   logic ref_tick;
   logic [6:0] sync_cnt;
   logic sync_tick;
   logic [6:0] rate_cnt;
   logic [5:0] filt_cnt;
   logic rx_s1;
   logic rx_s2;
   logic rx_prev;
   logic tx_s1;
   logic tx_s2;
   logic [3:0] phase;
   logic sync_active;
   logic edge_seen;
   logic sample_stb;
   logic pend_valid;
   logic pend_bit;
   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic fifo_rd_data;
   logic fifo_take;
   logic [4:0] lock_cnt;
   logic rate_clk;
   logic rate_clk_d;
   // Estimator state
   logic est_run;
   logic [6:0] est_sym;
   logic [6:0] est_target;
   logic est_start;

   always_comb
   begin
      cfg.front_amp_bypass = main_mode_power_control[7];
      cfg.amp_power_step = main_mode_power_control[6:4];
      cfg.sync_en = main_mode_power_control[3];                       // R20
      cfg.operating_state = rbf_op_t'(main_mode_power_control[2:1]);
      cfg.signal_level_detector_enable = detector_and_prefilter_control[3];
      cfg.pll_lock_indicator_enable = detector_and_prefilter_control[2];
      cfg.prefilter_cutoff_sel = detector_and_prefilter_control[1:0];
      cfg.sync_clock_setting = sync_clock_select_high[3:1];
      cfg.rate_clock_setting = {sync_clock_select_high[0],
                                rate_select_and_reference_divider[7:6]};
      cfg.reference_divider = rate_select_and_reference_divider[5:0];
      cfg.channel_filter_divider = channel_filter_clock_divider[5:0];
      cfg.channel_filter_bypass = bypass_control[0];
      cfg.amp_bypass = bypass_control[1];
      cfg.error_est_mode = rbf_est_t'(freq_error_control[1:0]);
      cfg.error_est_length = freq_error_control[3:2];
   end

   // Register writes
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         main_mode_power_control <= MAIN_FIXED;
         detector_and_prefilter_control <= DETECT_FIXED;
         sync_clock_select_high <= SYNC_FIXED;
         rate_select_and_reference_divider <= RATE_FIXED;
         channel_filter_clock_divider <= FILT_FIXED;
         bypass_control <= BYP_FIXED;
         freq_error_control <= EST_FIXED;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            ADDR_MAIN:
               main_mode_power_control <=
                  masked(reg_wdata, MAIN_WMASK, MAIN_FIXED);
            ADDR_DETECT:
               detector_and_prefilter_control <=
                  masked(reg_wdata, DETECT_WMASK, DETECT_FIXED);
            ADDR_SYNC_HI:
               sync_clock_select_high <=
                  masked(reg_wdata, SYNC_WMASK, SYNC_FIXED);
            ADDR_RATE_REF:
               rate_select_and_reference_divider <=
                  masked(reg_wdata, RATE_WMASK, RATE_FIXED);
            ADDR_FILT_DIV:
               channel_filter_clock_divider <=
                  masked(reg_wdata, FILT_WMASK, FILT_FIXED);
            ADDR_BYPASS:
               bypass_control <= masked(reg_wdata, BYP_WMASK, BYP_FIXED);
            ADDR_EST_CTL:
               freq_error_control <= masked(reg_wdata, EST_WMASK, EST_FIXED);
            default:
               ;
         endcase
      end
   end

   // Register reads, unmapped give zero
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         reg_rdata <= 8'h00;
      end
      else if (reg_rd)
      begin
         case (reg_addr)
            ADDR_MAIN: reg_rdata <= main_mode_power_control;
            ADDR_DETECT: reg_rdata <= detector_and_prefilter_control;
            ADDR_SYNC_HI: reg_rdata <= sync_clock_select_high;
            ADDR_RATE_REF: reg_rdata <= rate_select_and_reference_divider;
            ADDR_FILT_DIV: reg_rdata <= channel_filter_clock_divider;
            ADDR_BYPASS: reg_rdata <= bypass_control;
            ADDR_EST_CTL: reg_rdata <= freq_error_control;
            ADDR_EST_RES: reg_rdata <= freq_error_result;              // R8
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // Analog control outputs
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         prefilter_cutoff_sel <= 2'h0;
         channel_filter_bypass <= 1'b0;
         channel_filter_enable <= 1'b0;
         signal_level_detector_enable <= 1'b0;
         pll_lock_indicator_enable <= 1'b0;
         amp_on <= 1'b0;
         amp_power_step <= 3'h0;
         amp_bypass <= 1'b0;
         front_amp_bypass <= 1'b0;
      end
      else
      begin
         prefilter_cutoff_sel <= cfg.prefilter_cutoff_sel;              // R1
         channel_filter_bypass <= cfg.channel_filter_bypass;            // R4
         channel_filter_enable <= !cfg.channel_filter_bypass &&
                                  (cfg.channel_filter_divider != 6'h00); // R4
         signal_level_detector_enable <= cfg.signal_level_detector_enable;
         pll_lock_indicator_enable <= cfg.pll_lock_indicator_enable;
         amp_on <= (cfg.amp_power_step != 3'h0) &&
                   (cfg.operating_state == OP_TRANSMIT);                // R18
         amp_power_step <= cfg.amp_power_step;                          // R19
         amp_bypass <= cfg.amp_bypass;                                  // R19
         front_amp_bypass <= cfg.front_amp_bypass;
      end
   end

   // Filter clock, twenty times the cutoff
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         filt_cnt <= 6'h00;
         channel_filter_clk <= 1'b0;
      end
      else if (cfg.channel_filter_divider == 6'h00 ||
               cfg.channel_filter_bypass)
      begin
         filt_cnt <= 6'h00;                                             // R23
         channel_filter_clk <= 1'b0;                                    // R4
      end
      else if (filt_cnt >= cfg.channel_filter_divider - 6'h01)
      begin
         filt_cnt <= 6'h00;
         channel_filter_clk <= !channel_filter_clk;                     // R2 R3
      end
      else
      begin
         filt_cnt <= filt_cnt + 6'h01;
      end
   end

   // Shared reference prescaler
   assign ref_tick = (cfg.reference_divider != 6'h00) &&
                     (ref_cnt >= cfg.reference_divider - 6'h01);      // R16

   always_ff @(posedge core_clk)
   begin
      if (!reset_n || cfg.reference_divider == 6'h00)
      begin
         ref_cnt <= 6'h00;                                              // R23
      end
      else
      begin
         ref_cnt <= ref_tick ? 6'h00 : ref_cnt + 6'h01;                 // R15
      end
   end

   // Power-of-two clock stages
   assign sync_tick = ref_tick &&
                      (sync_cnt >= pow_limit(cfg.sync_clock_setting)); // R14

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         sync_cnt <= 7'h00;
         rate_cnt <= 7'h00;
      end
      else if (ref_tick)
      begin
         sync_cnt <= sync_tick ? 7'h00 : sync_cnt + 7'h01;
         rate_cnt <= (rate_cnt >= pow_limit(cfg.rate_clock_setting)) ?
                     7'h00 : rate_cnt + 7'h01;
      end
   end

   assign rate_clk = (rate_cnt <= (pow_limit(cfg.rate_clock_setting) >> 1));

   // Two-flop pin synchronisers
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         rx_s1 <= 1'b0;
         rx_s2 <= 1'b0;
         tx_s1 <= 1'b0;
         tx_s2 <= 1'b0;
      end
      else
      begin
         rx_s1 <= rx_bit_raw;
         rx_s2 <= rx_s1;
         tx_s1 <= data_io_pin_in;
         tx_s2 <= tx_s1;
      end
   end

   assign sync_active = cfg.sync_en &&
                        (cfg.operating_state == OP_RECEIVE);           // R11
   assign edge_seen = sync_tick && (rx_s2 != rx_prev);
   assign sample_stb = sync_active && sync_tick &&
                       (phase == PHASE_SAMPLE);

   // Phase tracking, one step per edge
   always_ff @(posedge core_clk)
   begin
      if (!reset_n || !sync_active)
      begin
         phase <= PHASE_EDGE;
         rx_prev <= 1'b0;
      end
      else if (sync_tick)
      begin
         rx_prev <= rx_s2;
         if (edge_seen && phase != PHASE_EDGE && phase < PHASE_SAMPLE)
         begin
            phase <= phase;                                             // R17
         end
         else if (edge_seen && phase >= PHASE_SAMPLE)
         begin
            phase <= phase + 4'h2;                                      // R17
         end
         else
         begin
            phase <= phase + 4'h1;
         end
      end
   end

   // Lock flag after acquisition span
   always_ff @(posedge core_clk)
   begin
      if (!reset_n || !sync_active)
      begin
         lock_cnt <= 5'h00;
         sync_locked <= 1'b0;
      end
      else if (sample_stb && !sync_locked)
      begin
         lock_cnt <= lock_cnt + 5'h01;
         sync_locked <= (lock_cnt + 5'h01 >= LOCK_BITS);                // R17
      end
   end

   // Sampled bit waits for the FIFO
   always_ff @(posedge core_clk)
   begin
      if (!reset_n || !sync_active)
      begin
         pend_valid <= 1'b0;
         pend_bit <= 1'b0;
      end
      else if (sample_stb && (!pend_valid || fifo_wr_ready))
      begin
         pend_valid <= 1'b1;
         pend_bit <= rx_s2;
      end
      else if (pend_valid && fifo_wr_ready)
      begin
         pend_valid <= 1'b0;
      end
   end

   assign fifo_take = sync_active && sync_tick &&
                      (phase == PHASE_EDGE) && fifo_rd_valid;

   rbf_fifo #(
      .WIDTH(1),
      .DEPTH(FIFO_DEPTH)
   ) u_bit_fifo (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .wr_valid(pend_valid),
      .wr_data(pend_bit),
      .wr_ready(fifo_wr_ready),
      .rd_valid(fifo_rd_valid),
      .rd_data(fifo_rd_data),
      .rd_ready(fifo_take)
   );

   // Data interface pins
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         data_clock_pin <= 1'b0;
         data_io_pin_out <= 1'b0;
         data_io_pin_oe <= 1'b0;
      end
      else
      begin
         data_io_pin_oe <= (cfg.operating_state == OP_RECEIVE);
         if (sync_active)
         begin
            data_clock_pin <= (phase < PHASE_SAMPLE);                   // R12
            if (fifo_take)
            begin
               data_io_pin_out <= fifo_rd_data;                         // R13
            end
         end
         else if (cfg.sync_en && cfg.operating_state == OP_TRANSMIT)
         begin
            data_clock_pin <= rate_clk;                                 // R16
         end
         else
         begin
            data_clock_pin <= 1'b0;
            data_io_pin_out <= rx_s2;
         end
      end
   end

   // Transmit data taken on rising data clock with sync on, every cycle with sync off
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         rate_clk_d <= 1'b0;
         tx_bit <= 1'b0;
      end
      else
      begin
         rate_clk_d <= data_clock_pin;
         if (!cfg.sync_en)
         begin
            tx_bit <= tx_s2;
         end
         else if (data_clock_pin && !rate_clk_d)
         begin
            tx_bit <= tx_s2;
         end
      end
   end

   // Frequency error estimator
   assign est_start = reg_wr && (reg_addr == ADDR_EST_CTL) &&
                      (reg_wdata[1:0] != EST_OFF);                      // R22
   assign est_target = 7'(EST_BASE_LEN << cfg.error_est_length);        // R7

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         est_run <= 1'b0;
         est_sym <= 7'h00;
         freq_error_result <= 8'h00;
      end
      else if (est_start)
      begin
         est_run <= 1'b1;                                               // R22
         est_sym <= 7'h00;
         freq_error_result <= 8'h00;
      end
      else if (!est_run || cfg.error_est_mode == EST_OFF)
      begin
         est_run <= 1'b0;                                               // R6
      end
      else
      begin
         case (cfg.error_est_mode)                                      // R5 R6
            EST_UP:
               if (demod_up)
               begin
                  freq_error_result <= freq_error_result + 8'h01;
               end
            EST_DOWN:
               if (demod_dn)
               begin
                  freq_error_result <= freq_error_result - 8'h01;       // R9
               end
            EST_BOTH:
               if (demod_up && !demod_dn)
               begin
                  freq_error_result <= freq_error_result + 8'h01;       // R21
               end
               else if (demod_dn && !demod_up)
               begin
                  freq_error_result <= freq_error_result - 8'h01;       // R21
               end
            default:
               ;
         endcase
         if (sample_stb)
         begin
            est_sym <= est_sym + 7'h01;
            if (est_sym + 7'h01 >= est_target)
            begin
               est_run <= 1'b0;                                         // R22
            end
         end
      end
   end

endmodule : rbf_ctrl
`default_nettype wire

// ===== tb/rbf_ctrl_assertions.sv
// Checker on the control ports
`timescale 1ns/1ps
`default_nettype none
module rbf_ctrl_assertions
   import rbf_pkg::*;
(
   // Clock, reset and writes
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic reg_wr,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   // Outputs
   input wire logic data_clock_pin,
   input wire logic data_io_pin_out,
   input wire logic sync_locked,
   input wire logic [1:0] prefilter_cutoff_sel,
   input wire logic channel_filter_clk,
   input wire logic channel_filter_enable,
   input wire logic channel_filter_bypass,
   input wire logic amp_on,
   input wire logic [2:0] amp_power_step
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_zero_div;
      reg_wr && reg_addr == ADDR_FILT_DIV && reg_wdata[5:0] == 6'h00;
   endsequence
   sequence s_cut_wr;
      reg_wr && reg_addr == ADDR_DETECT ##1 !reg_wr ##1 1'b1;
   endsequence
   property p_zero_div;
      s_zero_div ##1 (!reg_wr) [*4] |=> $stable(channel_filter_clk);
   endproperty
   a_zero_div: assert property (p_zero_div)
      else $error("zero divider clock");
   property p_cut;
      s_cut_wr |-> prefilter_cutoff_sel == $past(reg_wdata[1:0], 2);
   endproperty
   a_cut: assert property (p_cut)
      else $error("cutoff");
   property p_amp;
      amp_power_step == 3'h0 |-> !amp_on;
   endproperty
   a_amp: assert property (p_amp)
      else $error("amp on at zero");
   property p_byp;
      channel_filter_bypass |-> !channel_filter_enable;
   endproperty
   a_byp: assert property (p_byp)
      else $error("filter on in bypass");
   property p_byp_clk;
      channel_filter_bypass [*3] |-> $stable(channel_filter_clk);
   endproperty
   a_byp_clk: assert property (p_byp_clk)
      else $error("clock in bypass");
   property p_clk_hi;
      sync_locked && $rose(data_clock_pin) |=> data_clock_pin [*6];
   endproperty
   a_clk_hi: assert property (p_clk_hi)
      else $error("short high");
   property p_clk_lo;
      sync_locked && $fell(data_clock_pin) |=> !data_clock_pin [*6];
   endproperty
   a_clk_lo: assert property (p_clk_lo)
      else $error("short low");
   property p_data;
      sync_locked && $changed(data_io_pin_out) |-> data_clock_pin;
   endproperty
   a_data: assert property (p_data)
      else $error("data moved, clock low");
endmodule : rbf_ctrl_assertions
`default_nettype wire

// ===== tb/rbf_host_model.sv
// Host model on the data pins
`timescale 1ns/1ps
`default_nettype none
module rbf_host_model (
   // Data pins
   input wire logic data_clock_pin,
   input wire logic data_io_pin_out,
   input wire logic data_io_pin_oe,
   output logic data_io_pin_in,
   // Bits taken, newest at bit 0
   output logic [63:0] got
);
   initial
   begin
      data_io_pin_in = 1'b0;
      got = '0;
   end
   always @(negedge data_clock_pin)
   begin
      if (data_io_pin_oe)
         got <= {got[62:0], data_io_pin_out};
      data_io_pin_in <= ~data_io_pin_in;
   end
endmodule : rbf_host_model
`default_nettype wire

// ===== tb/tb_rbf_ctrl.sv
// Bench for the baseband control block
`timescale 1ns/1ps
`default_nettype none
module tb_rbf_ctrl;
   import rbf_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic rx_bit_raw = 1'b0;
   logic demod_up = 1'b0;
   logic demod_dn = 1'b0;
   logic data_io_pin_in, data_clock_pin, data_io_pin_out, data_io_pin_oe;
   logic tx_bit, sync_locked, channel_filter_clk, channel_filter_enable;
   logic channel_filter_bypass, signal_level_detector_enable, amp_on;
   logic pll_lock_indicator_enable, amp_bypass, front_amp_bypass;
   logic [7:0] reg_rdata;
   logic [1:0] prefilter_cutoff_sel;
   logic [2:0] amp_power_step;
   logic [63:0] got;
   logic [127:0] sent = '0;
   logic [7:0] wv [9];
   logic [6:0] ad [9] = '{7'h00, 7'h01, 7'h06, 7'h07, 7'h08, 7'h09,
      7'h15, 7'h16, 7'h7f};
   logic [7:0] rv [9] = '{8'h01, 8'h80, 0, 0, 8'hc0, 0, 0, 0, 0};
   logic [7:0] wm [9] = '{8'hfe, 8'h0f, 8'h0f, 8'hff, 8'h3f, 8'h03,
      8'h0f, 0, 0};
   int seed = 41;
   int n_errors = 0;
   int checks_done = 0;
   int ph = 0;
   int r, dv;
   always #2 core_clk = ~core_clk;
   rbf_ctrl dut (.*);
   rbf_host_model host (.*);
   always @(posedge core_clk)
   begin
      ph <= (ph + 1) % 16;
      if (ph == 0)
         sent <= {sent[126:0], 1'($random(seed))};
      rx_bit_raw <= sent[0];
   end
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   task automatic wr(logic [6:0] a, logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdc(string nm, logic [6:0] a, logic [7:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(nm, e, reg_rdata);
   endtask : rdc
   task automatic rises(int n);
      logic p;
      r = 0;
      p = channel_filter_clk;
      repeat (n)
      begin
         @(posedge core_clk);
         #1;
         r += int'(channel_filter_clk && !p);
         p = channel_filter_clk;
      end
   endtask : rises
   task automatic est(logic [1:0] m, logic [1:0] ln, int u, int d);
      logic [7:0] e;
      e = (m == 2'b01) ? 8'(u) : (m == 2'b10) ? 8'(-d) : 8'(u - d);
      wr(ADDR_EST_CTL, {4'h0, ln, m});
      for (int i = 0; i < (u > d ? u : d); i++)
      begin
         demod_up <= (i < u);
         demod_dn <= (i < d);
         @(posedge core_clk);
      end
      demod_dn <= 1'b0;
      demod_up <= 1'b0;
      repeat ((8 << ln) * 16 + 48) @(posedge core_clk);
      demod_up <= 1'b1;
      repeat (3) @(posedge core_clk);
      demod_up <= 1'b0;
      rdc("est", ADDR_EST_RES, e);
   endtask : est
   function automatic bit seen(logic [127:0] s, logic [63:0] g);
      seen = 0;
      for (int i = 0; i <= 64; i++)
         if (s[i +: 64] === g)
            seen = 1;
   endfunction : seen
   task automatic summarize;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   initial
   begin
      #200000;
      n_errors++;
      $display("Error run expected end seen timeout");
      summarize;
   end
   initial
   begin
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 9; i++)
         rdc("reset", ad[i], rv[i]);
      for (int i = 0; i < 9; i++)
      begin
         wv[i] = $random(seed);
         wr(ad[i], wv[i]);
      end
      for (int i = 0; i < 9; i++)
         rdc("register", ad[i], (wv[i] & wm[i]) | rv[i]);
      for (int p = 0; p < 8; p++)
      begin
         wr(ADDR_MAIN, {1'b0, 3'(p), 4'h7});
         wr(ADDR_DETECT, {6'h00, 2'(p)});
         wr(ADDR_BYPASS, {6'h00, 1'(p), 1'b0});
         repeat (2) @(posedge core_clk);
         #1;
         chk("amp_on", p != 0, amp_on);
         chk("amp_power_step", p, amp_power_step);
         chk("amp_bypass", p & 1, amp_bypass);
         chk("prefilter_cutoff_sel", p & 3, prefilter_cutoff_sel);
      end
      wr(ADDR_MAIN, 8'h05);
      wr(ADDR_BYPASS, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         dv = i == 0 ? 63 : i == 3 ? 0 : {$random(seed)} % 62 + 1;
         wr(ADDR_FILT_DIV, 8'(dv));
         repeat (2 * dv + 4) @(posedge core_clk);
         rises(dv == 0 ? 40 : 20 * dv);
         chk("filt rises", dv == 0 ? 0 : 10, r);
      end
      wr(ADDR_FILT_DIV, 8'h05);
      wr(ADDR_BYPASS, 8'h01);
      rises(40);
      chk("bypass rises", 0, r);
      chk("channel_filter_enable", 0, channel_filter_enable);
      wr(ADDR_BYPASS, 8'h00);
      wr(ADDR_RATE_REF, 8'h01);
      wr(ADDR_SYNC_HI, 8'h0e);
      wr(ADDR_MAIN, 8'h0d);
      repeat (480) @(posedge core_clk);
      #1;
      chk("sync_locked", 1, sync_locked);
      est(2'b11, 2'b00, {$random(seed)} % 100, {$random(seed)} % 100);
      est(2'b01, 2'b01, {$random(seed)} % 100, {$random(seed)} % 100);
      est(2'b10, 2'b10, {$random(seed)} % 100, 60);
      est(2'b10, 2'b11, 0, 300);
      wr(ADDR_EST_CTL, 8'h00);
      rdc("frozen est", ADDR_EST_RES, 8'hd4);
      chk("host bits", 1, seen(sent, got));
      summarize;
   end
endmodule : tb_rbf_ctrl
bind rbf_ctrl rbf_ctrl_assertions u_chk (.*);
`default_nettype wire
